// [usf_cfg.svh]
// constants for the serial status flags and bit rate divider block
// Function
// - set tx empty on shift load and reset
// - set tx complete when shifter idle, line high
// - set rx full on receive transfer
// - idle after ten or eleven ones
// - no idle flag while receiver sleeps
// - idle rearmed only after rx full or receiver disable
// - overrun on transfer while rx full
// - noise with rx full, not on overrun
// - framing error with rx full, not overrun
// - framing error blocks further receive transfers
// - bit rate is clock/16/first/second factor
// - first factor codes 1,3,4,13
// - second factor is power of two
// - counter clear only in test mode
// - spi clock from sample or bus clock
// - test xor of clocks onto tx pin
// - clock test bit write-only in test mode
// - interrupt when flag and its enable set
// - receiver disabled inhibits receive flags
`ifndef USF_CFG_SVH
`define USF_CFG_SVH
`define USF_ADDR_STATUS 12'h000
`define USF_ADDR_BAUD 12'h004
`define USF_ADDR_CTRL 12'h008
`define USF_ADDR_DATA 12'h00C
`define USF_ST_TXE 7
`define USF_ST_TXC 6
`define USF_ST_RXF 5
`define USF_ST_IDLE 4
`define USF_ST_OVR 3
`define USF_ST_NOISE 2
`define USF_ST_FRM 1
`define USF_BD_CLR 7
`define USF_BD_SPI 6
`define USF_BD_TEST 3
`define USF_CT_TIE 7
`define USF_CT_TX_COMPLETE_IRQ_ENABLE 6
`define USF_CT_RIE 5
`define USF_CT_IDLE_IRQ_ENABLE 4
`define USF_CT_TE 3
`define USF_CT_RE 2
`define USF_CT_SLEEP 1
`define USF_CT_NINE 0
`define USF_RST_BAUD 8'h00
`define USF_RST_CTRL 8'h00
`define USF_RT_DIV 16
`define USF_IDLE_8 4'hA
`define USF_IDLE_9 4'hB
`endif

// [usf_pkg.sv]
// types shared by the serial flag block
`default_nettype none
package usf_pkg;
    typedef enum logic [2:0] {
        USF_IDLE_S = 3'b001,
        USF_SETUP_S = 3'b010,
        USF_ACCESS_S = 3'b100
    } usf_bus_e;
    typedef logic [7:0] usf_byte_t;
endpackage
`default_nettype wire

// [usf_tick_if.sv]
// carrier for divider ticks and controls between block modules
`default_nettype none
interface usf_tick_if;
    logic clr; // divider chain clear
    logic [1:0] first_sel; // first divider select
    logic [2:0] second_sel; // second divider select
    logic rt_tick; // sixteen times bit rate
    logic bit_tick; // one bit rate
    modport gen (input clr, input first_sel, input second_sel, output rt_tick, output bit_tick);
    modport use_side (output clr, output first_sel, output second_sel, input rt_tick, input bit_tick);
endinterface
`default_nettype wire

// [usf_count_div.sv]
// one modulo counter stage emitting an enable pulse
`default_nettype none
module usf_count_div (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clr,
    input wire logic en,
    input wire logic [7:0] modulus,
    output logic tick
);
    logic [7:0] cnt_reg; // cycles seen so far
    wire wrap = en && (cnt_reg >= modulus - 8'h01); // last count of period
    // counter, cleared by reset or test clear
    always_ff @(posedge clk) begin
        if (sys_rst || clr) begin
            cnt_reg <= 8'h00;
        end else if (en) begin
            cnt_reg <= wrap ? 8'h00 : cnt_reg + 8'h01;
        end
    end
    assign tick = wrap;
endmodule // usf_count_div
`default_nettype wire

// [usf_baud_gen.sv]
// two stage prescaler and sixteen-times divider chain
`default_nettype none
`include "usf_cfg.svh"
module usf_baud_gen import usf_pkg::*; (
    input wire logic clk,
    input wire logic sys_rst,
    usf_tick_if.gen tk
);
    logic t1; // after first factor
    logic t2; // after second factor, the sample clock
    wire [7:0] m1 = (tk.first_sel == 2'h0) ? 8'h01 : (tk.first_sel == 2'h1) ? 8'h03 :
                    (tk.first_sel == 2'h2) ? 8'h04 : 8'h0D;
    wire [7:0] m2 = 8'h01 << tk.second_sel;
    // bus clock / first / second gives rt rate, then /16 gives bit rate
    usf_count_div u_s1 (.clk(clk), .sys_rst(sys_rst), .clr(tk.clr), .en(1'b1), .modulus(m1), .tick(t1));
    usf_count_div u_s2 (.clk(clk), .sys_rst(sys_rst), .clr(tk.clr), .en(t1), .modulus(m2), .tick(t2));
    usf_count_div u_s3 (.clk(clk), .sys_rst(sys_rst), .clr(tk.clr), .en(t2), .modulus(8'(`USF_RT_DIV)),
        .tick(tk.bit_tick));
    assign tk.rt_tick = t2;
endmodule // usf_baud_gen
`default_nettype wire

// [usf_serial_flags.sv]
// status flags, bit rate register and apb slave of the serial port
//
// The address map and the APB slave port were chosen for this implementation.
`default_nettype none
`include "usf_cfg.svh"
module usf_serial_flags import usf_pkg::*; (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic test_mode,
    input wire logic tx_shift_load,
    input wire logic tx_shift_busy,
    input wire logic tx_data_pin,
    input wire logic rx_char_ready,
    input wire logic [7:0] rx_char,
    input wire logic rx_noise,
    input wire logic rx_stop_zero,
    input wire logic rx_line,
    output logic tx_pin,
    output logic tx_data_valid,
    output logic [7:0] tx_data,
    output logic rt_clk_en,
    output logic bit_clk_en,
    output logic spi_clk_en,
    output logic irq_req
);
    usf_tick_if tk (); // divider link
    usf_bus_e bus_reg; // apb phase tracker
    usf_byte_t baud_reg; // bit rate divider control
    usf_byte_t ctrl_reg; // enables and modes
    usf_byte_t rxd_reg; // receive data register
    logic txe_reg, txc_reg, rxf_reg, idle_reg, ovr_reg, noi_reg, frm_reg; // status flags
    logic idle_arm_reg; // idle may be set again
    logic [3:0] ones_reg; // consecutive ones counter
    logic st_seen_reg; // status was read, arms clears
    logic test_tgl_reg; // bit-rate square wave
    logic rt_tgl_reg; // sample-rate square wave

    usf_baud_gen u_baud (.clk(clk), .sys_rst(sys_rst), .tk(tk.gen));
    assign tk.first_sel = baud_reg[5:4];
    assign tk.second_sel = baud_reg[2:0];
    assign tk.clr = test_mode && baud_reg[`USF_BD_CLR];

    // apb decode
    wire setup = psel && !penable;
    wire acc = psel && penable && pready;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;
    wire hit_st = paddr == `USF_ADDR_STATUS;
    wire hit_bd = paddr == `USF_ADDR_BAUD;
    wire hit_ct = paddr == `USF_ADDR_CTRL;
    wire hit_dt = paddr == `USF_ADDR_DATA;
    wire mapped = hit_st || hit_bd || hit_ct || hit_dt;
    wire rx_en = ctrl_reg[`USF_CT_RE];
    wire nine = ctrl_reg[`USF_CT_NINE];
    // clear sequences: status read then data access
    wire rx_clear = rd && hit_dt && st_seen_reg;
    wire tx_write = wr && hit_dt && st_seen_reg;
    // receive transfer allowed only with no overrun/framing pending
    wire rx_move = rx_en && rx_char_ready && !rxf_reg && !ovr_reg && !frm_reg;
    wire rx_over = rx_en && rx_char_ready && rxf_reg && !ovr_reg;
    wire [3:0] idle_need = nine ? `USF_IDLE_9 : `USF_IDLE_8;
    wire idle_hit = rx_en && (ones_reg == idle_need) && bit_clk_en;
    wire idle_set = idle_hit && idle_arm_reg && !ctrl_reg[`USF_CT_SLEEP];
    wire [7:0] status_byte = {txe_reg, txc_reg, rxf_reg, idle_reg, ovr_reg, noi_reg, frm_reg, 1'b0};
    // clear and test bits read back as zero
    wire [7:0] baud_rd = baud_reg & 8'h77;
    wire [7:0] rd_mux = hit_st ? status_byte : hit_bd ? baud_rd : hit_ct ? ctrl_reg : hit_dt ? rxd_reg : 8'h00;
    wire irq_next = (ctrl_reg[`USF_CT_TIE] && txe_reg) || (ctrl_reg[`USF_CT_TX_COMPLETE_IRQ_ENABLE] && txc_reg) ||
                    (ctrl_reg[`USF_CT_RIE] && (rxf_reg || ovr_reg)) ||
                    (ctrl_reg[`USF_CT_IDLE_IRQ_ENABLE] && idle_reg);
    wire test_out = test_tgl_reg ^ rt_tgl_reg;
    wire line_next = (test_mode && baud_reg[`USF_BD_TEST]) ? test_out : (txc_reg ? 1'b1 : tx_data_pin);

    // apb phase; one wait state so every answer comes from a register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_reg <= USF_IDLE_S;
            pready <= 1'b0;
        end else begin
            case (bus_reg)
                USF_IDLE_S: begin
                    if (setup) begin
                        bus_reg <= USF_SETUP_S;
                    end
                    pready <= 1'b0;
                end
                USF_SETUP_S: begin
                    bus_reg <= USF_ACCESS_S;
                    pready <= 1'b1;
                end
                USF_ACCESS_S: begin
                    bus_reg <= USF_IDLE_S;
                    pready <= 1'b0;
                end
                default: begin
                    bus_reg <= USF_IDLE_S;
                    pready <= 1'b0;
                end
            endcase
        end
    end

    // read data and error captured with pready
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            prdata <= {24'h000000, rd_mux};
            pslverr <= (bus_reg == USF_SETUP_S) && !mapped;
        end
    end

    // software registers; test bits forced low outside test mode
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            baud_reg <= `USF_RST_BAUD;
            ctrl_reg <= `USF_RST_CTRL;
        end else begin
            if (wr && hit_bd) begin
                baud_reg <= pwdata[7:0] & (test_mode ? 8'hFF : 8'h77);
            end else begin
                baud_reg[`USF_BD_CLR] <= 1'b0; // clear is a one-shot
                if (!test_mode) begin
                    baud_reg[`USF_BD_TEST] <= 1'b0;
                end
            end
            if (wr && hit_ct) begin
                ctrl_reg <= pwdata[7:0];
            end
        end
    end

    // status read arms the following data access
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_seen_reg <= 1'b0;
        end else if (rd && hit_st) begin
            st_seen_reg <= 1'b1;
        end else if (acc && hit_dt) begin
            st_seen_reg <= 1'b0;
        end
    end

    // transmit flags; hardware set wins over software clear for tx empty, a data write wins for tx complete
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            txe_reg <= 1'b1;
            txc_reg <= 1'b1;
            tx_data_valid <= 1'b0;
            tx_data <= 8'h00;
        end else begin
            if (tx_shift_load) begin
                txe_reg <= 1'b1;
                tx_data_valid <= 1'b0;
            end else if (tx_write) begin
                txe_reg <= 1'b0;
                tx_data_valid <= 1'b1;
            end
            if (tx_write) begin
                tx_data <= pwdata[7:0];
            end
            // complete when shifter empty and nothing queued
            if (!tx_shift_busy && !tx_data_valid && !tx_write) begin
                txc_reg <= 1'b1;
            end else if (tx_write || tx_shift_busy) begin
                txc_reg <= 1'b0;
            end
        end
    end

    // receive flags and data register
    always_ff @(posedge clk) begin
        if (sys_rst || !rx_en) begin
            rxf_reg <= 1'b0;
            ovr_reg <= 1'b0;
            noi_reg <= 1'b0;
            frm_reg <= 1'b0;
            idle_reg <= 1'b0;
            idle_arm_reg <= 1'b1;
            rxd_reg <= 8'h00;
        end else begin
            if (rx_move) begin
                rxf_reg <= 1'b1;
                noi_reg <= rx_noise;
                frm_reg <= rx_stop_zero;
                rxd_reg <= rx_char;
                idle_arm_reg <= 1'b1;
            end else if (rx_clear) begin
                rxf_reg <= 1'b0;
                noi_reg <= 1'b0;
                frm_reg <= 1'b0;
            end
            if (rx_over) begin
                ovr_reg <= 1'b1;
            end else if (rx_clear) begin
                ovr_reg <= 1'b0;
            end
            if (idle_set) begin
                idle_reg <= 1'b1;
                idle_arm_reg <= 1'b0;
            end else if (rx_clear) begin
                idle_reg <= 1'b0;
            end
        end
    end

    // consecutive ones on the line, counted per bit time
    always_ff @(posedge clk) begin
        if (sys_rst || !rx_line) begin
            ones_reg <= 4'h0;
        end else if (bit_clk_en && ones_reg != 4'hF) begin
            ones_reg <= ones_reg + 4'h1;
        end
    end

    // square waves of bit and sample rate for the test output
    always_ff @(posedge clk) begin
        if (sys_rst || tk.clr) begin
            test_tgl_reg <= 1'b0;
            rt_tgl_reg <= 1'b0;
        end else begin
            if (tk.bit_tick) begin
                test_tgl_reg <= !test_tgl_reg;
            end
            if (tk.rt_tick) begin
                rt_tgl_reg <= !rt_tgl_reg;
            end
        end
    end

    // registered outputs; spi source chosen by select bit
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_pin <= 1'b1;
            rt_clk_en <= 1'b0;
            bit_clk_en <= 1'b0;
            spi_clk_en <= 1'b0;
            irq_req <= 1'b0;
        end else begin
            tx_pin <= line_next;
            rt_clk_en <= tk.rt_tick;
            bit_clk_en <= tk.bit_tick;
            spi_clk_en <= baud_reg[`USF_BD_SPI] ? tk.rt_tick : 1'b1;
            irq_req <= irq_next;
        end
    end
endmodule // usf_serial_flags
`default_nettype wire

// [usf_checker.sv]
// port assertions for the serial flag block
`default_nettype none
`include "usf_cfg.svh"
module usf_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic test_mode,
    input wire logic tx_shift_load,
    input wire logic tx_shift_busy,
    input wire logic tx_data_valid,
    input wire logic tx_pin,
    input wire logic bit_clk_en,
    input wire logic irq_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic rd_done; // read completing at this edge
    assign rd_done = psel && penable && pready && !pwrite;
    // reset leaves the line marking and no request
    rst_out_a: assert property (disable iff (1'b0) sys_rst |=> tx_pin && !irq_req && !pready)
        else $error("outputs wrong after reset");
    setup_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("ready not after one wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    upper_zero_a: assert property (rd_done |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    rate_hidden_a: assert property (rd_done && paddr == `USF_ADDR_BAUD |-> !prdata[7] && !prdata[3])
        else $error("clear or test bit readable");
    // a bit tick is followed by at least eight cycles without one
    bit_gap_a: assert property (bit_clk_en |=> !bit_clk_en [*8])
        else $error("bit ticks too close");
    tx_mark_a: assert property ((!tx_shift_busy && !tx_data_valid && !test_mode) [*3] |=> tx_pin)
        else $error("idle line not high");
    load_clr_a: assert property (tx_shift_load && !(psel && pwrite) |=> !tx_data_valid)
        else $error("pending byte kept after load");
    cover property (rd_done && paddr == `USF_ADDR_DATA);
    cover property (pslverr);
    cover property (tx_shift_load);
endmodule // usf_checker
bind usf_serial_flags usf_checker u_chk (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr, .test_mode, .tx_shift_load, .tx_shift_busy, .tx_data_valid, .tx_pin,
    .bit_clk_en, .irq_req);
`default_nettype wire

// [usf_peer.sv]
// far side model: transmit shifter and receive deserializer
`default_nettype none
module usf_peer (
    input wire logic clk,
    input wire logic tx_data_valid,
    input wire logic [7:0] tx_data,
    output logic tx_shift_load,
    output logic tx_shift_busy,
    output logic tx_data_pin,
    output logic rx_char_ready,
    output logic [7:0] rx_char,
    output logic rx_noise,
    output logic rx_stop_zero
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh_reg; // byte being shifted
    logic [3:0] cnt_reg; // bits still to go
    initial begin
        {tx_shift_load, rx_char_ready, rx_noise, rx_stop_zero} = 4'h0;
        rx_char = 8'h00;
        sh_reg = 8'h00;
        cnt_reg = 4'h0;
    end
    // take a pending byte only once the shifter is empty
    always @(posedge clk) begin
        tx_shift_load <= 1'b0;
        if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
            sh_reg <= {1'b1, sh_reg[7:1]};
        end else if (tx_data_valid) begin
            tx_shift_load <= 1'b1;
            sh_reg <= tx_data;
            cnt_reg <= 4'h8;
        end
    end
    assign tx_shift_busy = cnt_reg != 4'h0;
    assign tx_data_pin = sh_reg[0] | !tx_shift_busy; // line marks when empty
    // one received character; qualifiers go stale (inverted) after the pulse
    task automatic send(input logic [7:0] c, input logic n, input logic f);
        rx_char <= c;
        rx_noise <= n;
        rx_stop_zero <= f;
        rx_char_ready <= 1'b1;
        @(posedge clk);
        rx_char_ready <= 1'b0;
        rx_char <= ~c;
        rx_noise <= ~n;
        rx_stop_zero <= ~f;
        @(posedge clk);
    endtask
endmodule // usf_peer
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the serial flag block
`default_nettype none
`include "usf_cfg.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, sys_rst, psel, penable, pwrite, test_mode, rx_line, pready, pslverr, err;
    logic tx_shift_load, tx_shift_busy, tx_data_pin, rx_char_ready, rx_noise, rx_stop_zero;
    logic tx_pin, tx_data_valid, rt_clk_en, bit_clk_en, spi_clk_en, irq_req;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] rx_char, tx_data;
    logic [7:0] got_tx = 8'h00; // last byte the shifter took
    int n_fail = 0;
    int tests_run = 0;
    localparam int FAC[4] = '{1, 3, 4, 13};
    usf_serial_flags u_dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .test_mode, .tx_shift_load, .tx_shift_busy, .tx_data_pin, .rx_char_ready,
        .rx_char, .rx_noise, .rx_stop_zero, .rx_line, .tx_pin, .tx_data_valid, .tx_data, .rt_clk_en,
        .bit_clk_en, .spi_clk_en, .irq_req);
    usf_peer u_peer (.clk, .tx_data_valid, .tx_data, .tx_shift_load, .tx_shift_busy, .tx_data_pin,
        .rx_char_ready, .rx_char, .rx_noise, .rx_stop_zero);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) if (tx_shift_load) got_tx <= tx_data;
    // one apb transfer; waits for ready with a bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        rd = prdata;
        err = pslverr;
        if (n == 20) n_fail++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        `CHK("read", e, rd[7:0])
    endtask
    // data write without status read first must not send
    task automatic t_tx;
        apb(1'b1, `USF_ADDR_CTRL, 8'h08);
        apb(1'b1, `USF_ADDR_DATA, 8'h11);
        rdchk(`USF_ADDR_STATUS, 8'hC0);
        `CHK("tx taken", 8'h00, got_tx)
        apb(1'b1, `USF_ADDR_DATA, 8'h5A);
        repeat (20) @(posedge clk);
        `CHK("tx byte", 8'h5A, got_tx)
        apb(1'b1, `USF_ADDR_CTRL, 8'h88);
        repeat (3) @(posedge clk);
        `CHK("irq on", 1'b1, irq_req)
        apb(1'b1, `USF_ADDR_CTRL, 8'h00);
        repeat (3) @(posedge clk);
        `CHK("irq off", 1'b0, irq_req)
    endtask
    task automatic t_reset;
        rdchk(`USF_ADDR_STATUS, 8'hC0);
        rdchk(`USF_ADDR_BAUD, 8'h00);
        apb(1'b0, 12'h010, 8'h00);
        `CHK("unmapped err", 1'b1, err)
    endtask
    // noise, overrun and framing, then clear by status and data reads
    task automatic t_rx;
        apb(1'b1, `USF_ADDR_CTRL, 8'h04);
        u_peer.send(8'hA5, 1'b1, 1'b0);
        rdchk(`USF_ADDR_STATUS, 8'hE4);
        u_peer.send(8'h3C, 1'b0, 1'b1);
        rdchk(`USF_ADDR_STATUS, 8'hEC);
        rdchk(`USF_ADDR_DATA, 8'hA5);
        rdchk(`USF_ADDR_STATUS, 8'hC0);
        u_peer.send(8'h81, 1'b0, 1'b1);
        rdchk(`USF_ADDR_STATUS, 8'hE2);
        rdchk(`USF_ADDR_DATA, 8'h81);
        apb(1'b1, `USF_ADDR_CTRL, 8'h00);
        u_peer.send(8'h42, 1'b1, 1'b1);
        rdchk(`USF_ADDR_STATUS, 8'hC0);
        apb(1'b1, `USF_ADDR_CTRL, 8'h04);
    endtask
    task automatic t_idle;
        rx_line <= 1'b1;
        repeat (300) @(posedge clk);
        rdchk(`USF_ADDR_STATUS, 8'hD0);
        apb(1'b0, `USF_ADDR_DATA, 8'h00);
        // line active then idle again, but no character: must stay quiet
        rx_line <= 1'b0;
        repeat (20) @(posedge clk);
        rx_line <= 1'b1;
        repeat (300) @(posedge clk);
        rdchk(`USF_ADDR_STATUS, 8'hC0);
        rx_line <= 1'b0;
        // a character rearms idle, but a sleeping receiver ignores it
        u_peer.send(8'h00, 1'b0, 1'b0);
        rdchk(`USF_ADDR_STATUS, 8'hE0);
        rdchk(`USF_ADDR_DATA, 8'h00);
        apb(1'b1, `USF_ADDR_CTRL, 8'h06);
        rx_line <= 1'b1;
        repeat (300) @(posedge clk);
        rdchk(`USF_ADDR_STATUS, 8'hC0);
        rx_line <= 1'b0;
    endtask
    // second gap between bit ticks, after the change has settled
    task automatic period(input logic [7:0] b, input int e);
        int n;
        apb(1'b1, `USF_ADDR_BAUD, b);
        for (int k = 0; k < 3; k++) begin
            n = 0;
            @(posedge clk);
            while (bit_clk_en !== 1'b1 && n < 3000) begin
                @(posedge clk);
                n++;
            end
        end
        `CHK("bit period", e, n + 1)
    endtask
    task automatic t_rate;
        for (int i = 0; i < 4; i++) begin
            period({2'b00, 2'(i), 4'h0}, 16 * FAC[i]);
        end
        for (int j = 0; j < 8; j++) begin
            period({5'h00, 3'(j)}, 16 << j);
        end
        period(8'h3B, 16 * 13 * 8);
    endtask
    // first factor three: sample ticks every third cycle in both cases
    task automatic t_clk;
        int lo;
        int hi;
        int mis;
        for (int s = 0; s < 2; s++) begin
            lo = 0;
            hi = 0;
            mis = 0;
            apb(1'b1, `USF_ADDR_BAUD, (s == 1) ? 8'h50 : 8'h10);
            repeat (60) begin
                @(posedge clk);
                lo += int'(spi_clk_en !== 1'b1);
                hi += int'(rt_clk_en === 1'b1);
                mis += int'((s == 1) && (spi_clk_en !== rt_clk_en));
            end
            `CHK("spi low", s == 1, lo > 30)
            `CHK("spi follows rt", 0, mis)
            `CHK("rt ticks", 20, hi)
        end
    endtask
    task automatic t_test;
        int tog;
        logic pv;
        tog = 0;
        pv = tx_pin;
        test_mode <= 1'b1;
        apb(1'b1, `USF_ADDR_BAUD, 8'h18);
        rdchk(`USF_ADDR_BAUD, 8'h10);
        repeat (64) begin
            @(posedge clk);
            tog += int'(tx_pin != pv);
            pv = tx_pin;
        end
        test_mode <= 1'b0;
        `CHK("test toggles", 1'b1, tog > 2)
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        {sys_rst, psel, penable, pwrite, test_mode, rx_line} = 6'b100000;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_tx;
        t_reset;
        t_rx;
        t_idle;
        t_rate;
        t_clk;
        t_test;
        conclude;
    end
    // hang guard well beyond the expected run
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        conclude;
    end
endmodule // tb_top
`default_nettype wire
